// File: logic/tpcs_top.sv
// two-phase clock generator with refresh freeze and slow-memory stretch
`timescale 1ns/1ns
`default_nettype none
`include "tpcs_defines.svh"

// Overview of operation
// - low refresh ask at phase-one rise freezes
// - refresh grant high during freeze
// - high ask at next phase-one edge resumes
// - low ready at phase-two rise stretches
// - stretch lasts until ready goes high
// - refresh ask synchronised before use
// - bus phase two in phase with phase two
// - memory clock leads phase two
// - phases complementary, non-overlapping, 1 MHz
// - high times above 430/450 ns minimums
// - separate buffered phase two for loads
module tpcs_top #(
   parameter int SYNC_IDLE = 1   // refresh ask idle level
) (
   input  wire logic clk,
   input  wire logic nrst,
   input  wire logic refresh_ask_n,     // async refresh request, low active
   input  wire logic mem_ready,         // slow memory go, low stretches
   output var  logic ph1,               // processor phase one
   output var  logic ph2,               // processor phase two
   output var  logic bus_ph2,           // buffered phase two for other loads
   output var  logic dmem_clk,          // dynamic memory clock
   output var  logic refresh_grant      // refresh cycle in progress
);
   localparam tpcs_pkg::tpcs_cnt_t CYC_C  = 8'(`TPCS_CYC_CLKS);
   localparam tpcs_pkg::tpcs_cnt_t PH1_C  = 8'(`TPCS_PH1_CLKS);
   localparam tpcs_pkg::tpcs_cnt_t PH2_C  = 8'(`TPCS_PH2_CLKS);
   localparam tpcs_pkg::tpcs_cnt_t GAP_C  = 8'(`TPCS_GAP_CLKS);
   localparam tpcs_pkg::tpcs_cnt_t LEAD_C = 8'(`TPCS_LEAD_CLKS);

   // ------------------------------------------------------------
   // elaboration checks
   // ------------------------------------------------------------
   if (`TPCS_CYC_CLKS > 255 || `TPCS_LEAD_CLKS < 1 || `TPCS_LEAD_CLKS >= `TPCS_GAP_CLKS
       || `TPCS_PH1_CLKS + `TPCS_PH2_CLKS + 2 * `TPCS_GAP_CLKS > `TPCS_CYC_CLKS) begin : g_bad
      $error("tpcs_top: timing counts cannot be served");
   end
   if (SYNC_IDLE < 0 || SYNC_IDLE > 1) begin : g_bad_idle
      $error("tpcs_top: SYNC_IDLE must be 0 or 1");
   end

   // ------------------------------------------------------------
   // refresh ask synchroniser
   // ------------------------------------------------------------
   tpcs_sync_if ref_if ();                 // carrier to the synchroniser
   wire logic   ask_n_s;                   // retimed refresh ask

   assign ref_if.async_in = refresh_ask_n;
   tpcs_sync #(
      .RST_VAL (1'(SYNC_IDLE))
   ) u_ref_sync (
      .clk  (clk),
      .nrst (nrst),
      .sif  (ref_if)
   );
   assign ask_n_s = ref_if.sync_out;

   // ------------------------------------------------------------
   // state and counter
   // ------------------------------------------------------------
   tpcs_pkg::tpcs_state_e state_r;         // current phase state
   tpcs_pkg::tpcs_state_e state_nxt;
   tpcs_pkg::tpcs_cnt_t   cnt_r;           // clocks into current state
   tpcs_pkg::tpcs_cnt_t   cnt_nxt;
   logic                  stretch_r;       // phase two held by slow memory
   logic                  stretch_nxt;
   wire  tpcs_pkg::tpcs_cnt_t lim;         // length of current state
   wire  logic            hold;            // counter frozen by stretch
   wire  logic            done;            // current state ends this clock
   wire  logic            ph2_rise;        // phase two begins next clock

   assign lim = (state_r == tpcs_pkg::ST_PH1)    ? PH1_C :
                (state_r == tpcs_pkg::ST_PH2)    ? PH2_C :
                (state_r == tpcs_pkg::ST_FREEZE) ? CYC_C : GAP_C;
   // counter waits while stretching and ready is low
   assign hold     = stretch_r && !mem_ready;
   assign done     = (cnt_r == lim - 8'h01) && !hold;
   assign ph2_rise = done && (state_r == tpcs_pkg::ST_GAP12);

   // next state
   always_comb begin
      state_nxt = state_r;
      if (done) begin
         unique case (state_r)
            tpcs_pkg::ST_PH1:    state_nxt = tpcs_pkg::ST_GAP12;
            tpcs_pkg::ST_GAP12:  state_nxt = tpcs_pkg::ST_PH2;
            tpcs_pkg::ST_PH2:    state_nxt = tpcs_pkg::ST_GAP21;
            tpcs_pkg::ST_GAP21:  state_nxt = ask_n_s ? tpcs_pkg::ST_PH1 : tpcs_pkg::ST_FREEZE;
            tpcs_pkg::ST_FREEZE: state_nxt = ask_n_s ? tpcs_pkg::ST_PH1 : tpcs_pkg::ST_FREEZE;
            default:             state_nxt = tpcs_pkg::ST_PH1;
         endcase
      end
   end

   // counter restarts on each state change or freeze period
   assign cnt_nxt = done ? 8'h00 : (hold ? cnt_r : cnt_r + 8'h01);
   assign stretch_nxt = ph2_rise ? !mem_ready : (stretch_r && !mem_ready);

   // ------------------------------------------------------------
   // output next values
   // ------------------------------------------------------------
   wire logic ph1_nxt;     // phase one level
   wire logic ph2_nxt;     // phase two level
   wire logic grant_nxt;   // refresh grant level
   wire logic dmem_nxt;    // memory clock level

   assign ph1_nxt   = (state_nxt == tpcs_pkg::ST_PH1) || (state_nxt == tpcs_pkg::ST_FREEZE);
   assign ph2_nxt   = (state_nxt == tpcs_pkg::ST_PH2);
   assign grant_nxt = (state_nxt == tpcs_pkg::ST_FREEZE);
   // memory clock rises and falls early
   assign dmem_nxt  = ((state_nxt == tpcs_pkg::ST_GAP12) && (cnt_nxt >= GAP_C - LEAD_C))
                   || ((state_nxt == tpcs_pkg::ST_PH2) && (cnt_nxt < PH2_C - LEAD_C));

   // ------------------------------------------------------------
   // registers
   // ------------------------------------------------------------
   // known state, grant low after reset
   always_ff @(posedge clk) begin
      if (!nrst) begin
         state_r   <= tpcs_pkg::ST_GAP21;
         cnt_r     <= 8'h00;
         stretch_r <= 1'b0;
      end else begin
         state_r   <= state_nxt;
         cnt_r     <= cnt_nxt;
         stretch_r <= stretch_nxt;
      end
   end

   // output registers, with a separate bus copy of phase two
   always_ff @(posedge clk) begin
      if (!nrst) begin
         ph1           <= 1'b0;
         ph2           <= 1'b0;
         bus_ph2       <= 1'b0;
         dmem_clk      <= 1'b0;
         refresh_grant <= 1'b0;
      end else begin
         ph1           <= ph1_nxt;
         ph2           <= ph2_nxt;
         bus_ph2       <= ph2_nxt;
         dmem_clk      <= dmem_nxt;
         refresh_grant <= grant_nxt;
      end
   end

   // ------------------------------------------------------------
   // checks
   // ------------------------------------------------------------
   logic [7:0] hi1_r;   // clocks phase one has been high
   logic [7:0] frz_r;   // clocks grant has been high
   logic [7:0] hi2_r;   // clocks phase two has been high

   // helper run-length counters
   always_ff @(posedge clk) begin
      if (!nrst) begin
         hi1_r <= 8'h00;
         frz_r <= 8'h00;
         hi2_r <= 8'h00;
      end else begin
         hi1_r <= ph1 ? ((hi1_r == 8'hFF) ? hi1_r : hi1_r + 8'h01) : 8'h00;
         hi2_r <= ph2 ? ((hi2_r == 8'hFF) ? hi2_r : hi2_r + 8'h01) : 8'h00;
         frz_r <= refresh_grant ? ((frz_r == 8'hFF) ? frz_r : frz_r + 8'h01) : 8'h00;
      end
   end

   AST_NO_OVERLAP: assert property (@(posedge clk) disable iff (!nrst)
      !(ph1 && ph2)) else $error("phases overlap");
   AST_GAP_AFTER_PH2: assert property (@(posedge clk) disable iff (!nrst)
      $fell(ph2) |-> !ph1 [*8]) else $error("gap after phase two too short");
   AST_PH1_WIDTH: assert property (@(posedge clk) disable iff (!nrst)
      $fell(ph1) |-> $past(hi1_r) >= 8'(`TPCS_PH1_CLKS - 1)) else $error("phase one too short");
   AST_PH2_WIDTH: assert property (@(posedge clk) disable iff (!nrst)
      $fell(ph2) |-> $past(hi2_r) >= 8'(`TPCS_PH2_CLKS - 1)) else $error("phase two too short");
   AST_FREEZE_LEVELS: assert property (@(posedge clk) disable iff (!nrst)
      refresh_grant |-> ph1 && !ph2) else $error("freeze levels wrong");
   AST_FREEZE_LEN: assert property (@(posedge clk) disable iff (!nrst)
      $fell(refresh_grant) |-> $past(frz_r) >= 8'(`TPCS_CYC_CLKS - 1)) else $error("freeze too short");
   AST_RESUME: assert property (@(posedge clk) disable iff (!nrst)
      $fell(refresh_grant) |-> ph1 && $past(ask_n_s)) else $error("resume without ask high");
   AST_ENTER_FREEZE: assert property (@(posedge clk) disable iff (!nrst)
      (state_r == tpcs_pkg::ST_GAP21 && done && !ask_n_s) |=> refresh_grant && $rose(ph1))
      else $error("freeze not entered");
   AST_STRETCH: assert property (@(posedge clk) disable iff (!nrst)
      (ph2 && stretch_r && !mem_ready) |=> ph2) else $error("phase two dropped while not ready");
   AST_BUS_PHASE: assert property (@(posedge clk) disable iff (!nrst)
      bus_ph2 == ph2) else $error("bus phase two out of phase");
   AST_DMEM_LEAD: assert property (@(posedge clk) disable iff (!nrst)
      $rose(dmem_clk) |-> !ph2 ##2 $rose(ph2)) else $error("memory clock lead wrong");
   AST_DMEM_FALL: assert property (@(posedge clk) disable iff (!nrst)
      $fell(dmem_clk) |-> ph2 ##2 $fell(ph2)) else $error("memory clock fall lead wrong");
   AST_GAP_AFTER_PH1: assert property (@(posedge clk) disable iff (!nrst)
      $fell(ph1) |-> !ph2 [*8]) else $error("gap after phase one too short");
endmodule
`default_nettype wire

// File: inc/tpcs_defines.svh
// timing constants and counts for the two-phase clock stretcher
`ifndef TPCS_DEFINES_SVH
`define TPCS_DEFINES_SVH

// system clock rate
`define TPCS_CLK_MHZ      250
// one processor clock cycle, 1 MHz
`define TPCS_CYC_NS       1000
// phase one high time, minimum 430 ns plus margin
`define TPCS_PH1_NS       460
// phase two high time, minimum 450 ns plus margin
`define TPCS_PH2_NS       465
// each non-overlap gap
`define TPCS_GAP_NS       36
// lead of the memory clock ahead of phase two
`define TPCS_LEAD_NS      8

// least times round up to whole clocks
`define TPCS_CYC_CLKS     ((`TPCS_CYC_NS  * `TPCS_CLK_MHZ + 999) / 1000)
`define TPCS_PH1_CLKS     ((`TPCS_PH1_NS  * `TPCS_CLK_MHZ + 999) / 1000)
`define TPCS_PH2_CLKS     ((`TPCS_PH2_NS  * `TPCS_CLK_MHZ + 999) / 1000)
`define TPCS_GAP_CLKS     ((`TPCS_GAP_NS  * `TPCS_CLK_MHZ + 999) / 1000)
// lead is a longest time, rounds down
`define TPCS_LEAD_CLKS    ((`TPCS_LEAD_NS * `TPCS_CLK_MHZ) / 1000)

`endif

// File: inc/tpcs_pkg.sv
// types shared by the two-phase clock stretcher
`default_nettype none
package tpcs_pkg;
   // phase generator states
   typedef enum logic [2:0] {
      ST_PH1,
      ST_GAP12,
      ST_PH2,
      ST_GAP21,
      ST_FREEZE
   } tpcs_state_e;
   // phase counter
   typedef logic [7:0] tpcs_cnt_t;
endpackage
`default_nettype wire

// File: inc/tpcs_sync_if.sv
// carrier between the top and its input synchroniser
`timescale 1ns/1ns
`default_nettype none
interface tpcs_sync_if;
   logic async_in;   // raw asynchronous level
   logic sync_out;   // level retimed to clk
   modport sync (input async_in, output sync_out);
   modport user (output async_in, input sync_out);
endinterface
`default_nettype wire

// File: logic/tpcs_sync.sv
// two-flop level synchroniser
`timescale 1ns/1ns
`default_nettype none
module tpcs_sync #(
   parameter logic RST_VAL = 1'b1   // idle level after reset
) (
   input  wire logic  clk,
   input  wire logic  nrst,
   tpcs_sync_if.sync  sif
);
   logic meta_r;   // first stage, read only by the second
   logic hold_r;   // second stage

   // ------------------------------------------------------------
   // retiming flops
   // ------------------------------------------------------------
   always_ff @(posedge clk) begin
      if (!nrst) begin
         meta_r <= RST_VAL;
         hold_r <= RST_VAL;
      end else begin
         meta_r <= sif.async_in;
         hold_r <= meta_r;
      end
   end

   assign sif.sync_out = hold_r;
endmodule
`default_nettype wire

// File: verification/tpcs_mem_model.sv
// memory controller model: refresh asker and slow-memory ready
`timescale 1ns/1ns
`default_nettype none
module tpcs_mem_model (
   input  wire logic        clk,
   input  wire logic        nrst,
   input  wire logic        ph1,
   input  wire logic        ph2,
   input  wire logic        refresh_grant,
   input  wire logic        do_refresh,          // bench asks for refresh
   input  wire logic [15:0] stretch_clks,        // 0: no stretch
   output var  logic        refresh_ask_n = 1'b1,
   output var  logic        mem_ready     = 1'b1
);
   logic ph1_q = 1'b0;   // ph1 one cycle back
   int   left  = 0;      // ready-low clocks still owed

   // drive at falling edge, like the rest of the bench
   always @(negedge clk) begin
      ph1_q <= ph1;
      if (!nrst) begin
         refresh_ask_n <= 1'b1;
         mem_ready     <= 1'b1;
         left          <= 0;
      end else begin
         // ask back high on grant
         // ask is kept low while the bench still asks
         if (refresh_grant === 1'b1 && !do_refresh) begin
            refresh_ask_n <= 1'b1;
         end else if (do_refresh) begin
            refresh_ask_n <= 1'b0;
         end
         // ready low across ph2 rise, held a set count
         if (ph1_q && !ph1 && stretch_clks != 16'h0000) begin
            mem_ready <= 1'b0;
            left      <= int'(stretch_clks);
         end else if (!mem_ready && ph2) begin
            if (left <= 1) begin
               mem_ready <= 1'b1;
            end
            left <= left - 1;
         end
      end
   end
endmodule
`default_nettype wire

// File: verification/two_phase_clock_stretcher_bench.sv
// testbench for the two-phase clock stretcher
`timescale 1ns/1ns
`default_nettype none
module two_phase_clock_stretcher_bench;
   logic        clk          = 1'b0;     // 250 MHz
   logic        nrst         = 1'b0;     // sync reset, low active
   logic        do_refresh   = 1'b0;     // refresh command to model
   logic [15:0] stretch_clks = 16'h0000; // stretch command to model
   logic        run_chk      = 1'b0;     // monitor enable
   wire  logic  refresh_ask_n, mem_ready, ph1, ph2, bus_ph2, dmem_clk, refresh_grant;
   int          failures     = 0;
   int          n_checks     = 0;
   int          n;                       // measured run length

   always #2 clk = ~clk;

   tpcs_top tpcs_top_inst (.clk(clk), .nrst(nrst), .refresh_ask_n(refresh_ask_n),
      .mem_ready(mem_ready), .ph1(ph1), .ph2(ph2), .bus_ph2(bus_ph2),
      .dmem_clk(dmem_clk), .refresh_grant(refresh_grant));
   tpcs_mem_model tpcs_mem_model_inst (.clk(clk), .nrst(nrst), .ph1(ph1), .ph2(ph2),
      .refresh_grant(refresh_grant), .do_refresh(do_refresh), .stretch_clks(stretch_clks),
      .refresh_ask_n(refresh_ask_n), .mem_ready(mem_ready));

   // ----------------------------------------
   // helpers
   // ----------------------------------------
   task automatic tally_and_finish();
      $display("checks %0d mismatches %0d", n_checks, failures);
      if (failures == 0 && n_checks > 0) begin
         $display("SIMULATION PASSED");
      end else begin
         $display("SIMULATION FAILED");
      end
      $finish;
   endtask

   task automatic check(input string what, input logic [31:0] exp, input logic [31:0] got);
      n_checks++;
      if (got !== exp) begin
         failures++;
         $display("MISMATCH %s expected %0d seen %0d", what, exp, got);
      end
   endtask

   function automatic logic pick(input int sel);
      case (sel)
         0: pick = ph1;
         1: pick = ph2;
         2: pick = dmem_clk;
         default: pick = refresh_grant;
      endcase
   endfunction

   // clocks while the chosen output stays at v, bounded
   task automatic run_len(input int sel, input logic v, output int len);
      len = 0;
      while (pick(sel) === v && len < 3000) begin
         @(negedge clk);
         len++;
      end
      if (len >= 3000) begin
         check("wait bound", 0, len);
         tally_and_finish();
      end
   endtask

   // ----------------------------------------
   // monitor
   // ----------------------------------------
   always @(negedge clk) begin
      if (run_chk) begin
         check("bus_ph2", ph2, bus_ph2);
         check("overlap", 0, ph1 & ph2);
         if (refresh_grant === 1'b1) begin
            check("frozen ph1 ph2", 2'b10, {ph1, ph2});
         end
      end
   end

   // ----------------------------------------
   // scenarios
   // ----------------------------------------
   task automatic normal_cycle();
      run_len(0, 0, n);
      run_len(0, 1, n);
      check("ph1 high", 115, n);
      run_len(2, 0, n);
      check("gap to dmem rise", 7, n);
      run_len(1, 0, n);
      check("dmem lead", 2, n);
      run_len(1, 1, n);
      check("ph2 high", 117, n);
      run_len(0, 0, n);
      check("ph2 to ph1 gap", 9, n);
   endtask

   task automatic refresh_freeze();
      do_refresh <= 1'b1;
      run_len(0, 1, n);
      run_len(0, 0, n);
      check("grant with ph1", 1, refresh_grant);
      do_refresh <= 1'b0;
      run_len(3, 1, n);
      check("freeze length", 250, n);
      stretch_clks <= 16'h0028;
      run_len(0, 1, n);
      check("ph1 after freeze", 115, n);
   endtask

   task automatic slow_stretch();
      run_len(1, 0, n);
      check("ph1 to ph2 gap", 9, n);
      stretch_clks <= 16'h0000;
      run_len(1, 1, n);
      n_checks++;
      // ph2 held high by the ready count
      if (n < 117 + 40 - 2 || n > 117 + 40 + 2) begin
         failures++;
         $display("MISMATCH stretched ph2 expected %0d seen %0d", 157, n);
      end
      run_len(0, 0, n);
      check("gap after stretch", 9, n);
   endtask

   // ask held low past one freeze period: two periods
   task automatic long_freeze();
      do_refresh <= 1'b1;
      run_len(0, 1, n);
      run_len(0, 0, n);
      check("grant at long freeze", 1, refresh_grant);
      repeat (260) @(negedge clk);
      do_refresh <= 1'b0;
      run_len(3, 1, n);
      check("long freeze length", 500, n + 260);
      run_len(0, 1, n);
      check("ph1 after long freeze", 115, n);
   endtask

   // reset in mid-run, then the first gap and phase one
   task automatic mid_reset();
      nrst <= 1'b0;
      repeat (3) @(negedge clk);
      nrst <= 1'b1;
      @(negedge clk);
      check("outputs after mid reset", 0, {ph1, ph2, bus_ph2, dmem_clk, refresh_grant});
      run_len(0, 0, n);
      check("gap before first ph1", 8, n);
      run_len(0, 1, n);
      check("ph1 after mid reset", 115, n);
   endtask

   initial begin
      repeat (12) @(negedge clk);
      nrst <= 1'b1;
      @(negedge clk);
      check("outputs after reset", 0, {ph1, ph2, bus_ph2, dmem_clk, refresh_grant});
      run_chk = 1'b1;
      normal_cycle();
      refresh_freeze();
      slow_stretch();
      long_freeze();
      mid_reset();
      tally_and_finish();
   end
endmodule
`default_nettype wire
